/* File: src/gcis_pkg.sv */
// Summary of operation
// R01: framer summary bit set while framer interrupts
// R02: channel one bit 0, channel eight bit 7
// R03: read-only tester summary byte at 0xfa
// R04: line interface summary byte at 0xfb
// R05: summary bit zero while source idle
// R06: framer enable byte, one enables channel
// R07: tester enable byte, one enables channel
// R08: line enable byte, one enables channel
// R09: framer summary byte at 0xf9
// R10: interrupt asserted on any enabled pending bit
// R11: summary writes ignored, bits follow sources
package gcis_pkg;
   localparam int unsigned CHANNELS = 8;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam logic [15:0] FRAMER_SUM_ADDR = 16'h00f9;
   localparam logic [15:0] TESTER_SUM_ADDR = 16'h00fa;
   localparam logic [15:0] LINE_SUM_ADDR = 16'h00fb;
   localparam logic [15:0] FRAMER_EN_ADDR = 16'h00fc;
   localparam logic [15:0] TESTER_EN_ADDR = 16'h00fd;
   localparam logic [15:0] LINE_EN_ADDR = 16'h00fe;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] SUMMARY_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : gcis_pkg

/* File: src/gcis_sync8.sv */
`timescale 1ns/100ps
// three-stage synchroniser; output moves once stages two and three agree
module gcis_sync8 (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] async_in,
   output logic [7:0] sync_out
);
   logic [7:0] s1_r;
   logic [7:0] s2_r;
   logic [7:0] s3_r;
   logic [7:0] out_r;
   logic [7:0] out_nxt;

   assign out_nxt = (s2_r & s3_r) | (out_r & (s2_r | s3_r));
   assign sync_out = out_r;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s1_r <= gcis_pkg::SUMMARY_RESET;
         s2_r <= gcis_pkg::SUMMARY_RESET;
         s3_r <= gcis_pkg::SUMMARY_RESET;
         out_r <= gcis_pkg::SUMMARY_RESET;
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         out_r <= out_nxt;
      end
   end
endmodule : gcis_sync8

/* File: src/gcis_enable_reg.sv */
`timescale 1ns/100ps
// one writable enable byte
module gcis_enable_reg (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic wr_sel,
   input wire logic [7:0] wr_data,
   output logic [7:0] value
);
   logic [7:0] value_r;

   assign value = value_r;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         value_r <= gcis_pkg::ENABLE_RESET;
      end else if (wr_sel) begin
         value_r <= wr_data;
      end
   end
endmodule : gcis_enable_reg

/* File: src/gcis_irq_summary.sv */
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
// global per-channel interrupt summary with enable masks
module gcis_irq_summary (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [7:0] framer_irq_in,
   input wire logic [7:0] tester_irq_in,
   input wire logic [7:0] line_irq_in,
   output logic irq_out,
   output logic [7:0] framer_pending_per_channel,
   output logic [7:0] tester_pending_per_channel,
   output logic [7:0] line_pending_per_channel
);
   logic [7:0] framer_sync;
   logic [7:0] tester_sync;
   logic [7:0] line_sync;
   logic [7:0] framer_enable_per_channel;
   logic [7:0] tester_enable_per_channel;
   logic [7:0] line_enable_per_channel;
   logic [7:0] framer_sum_r;
   logic [7:0] tester_sum_r;
   logic [7:0] line_sum_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic irq_r;
   logic irq_nxt;
   logic hit_fs;
   logic hit_ts;
   logic hit_ls;
   logic hit_fe;
   logic hit_te;
   logic hit_le;

   function automatic logic addr_hit(input logic [15:0] a,
                                     input logic [15:0] base);
      addr_hit = (a == base);
   endfunction : addr_hit

   // input index i is channel i+1, so channel one lands on bit 0
   gcis_sync8 u_sync_framer (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .async_in(framer_irq_in), // R02
      .sync_out(framer_sync)
   );
   gcis_sync8 u_sync_tester (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .async_in(tester_irq_in),
      .sync_out(tester_sync)
   );
   gcis_sync8 u_sync_line (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .async_in(line_irq_in),
      .sync_out(line_sync)
   );

   assign hit_fs = addr_hit(reg_addr, gcis_pkg::FRAMER_SUM_ADDR); // R09
   assign hit_ts = addr_hit(reg_addr, gcis_pkg::TESTER_SUM_ADDR); // R03
   assign hit_ls = addr_hit(reg_addr, gcis_pkg::LINE_SUM_ADDR); // R04
   assign hit_fe = addr_hit(reg_addr, gcis_pkg::FRAMER_EN_ADDR);
   assign hit_te = addr_hit(reg_addr, gcis_pkg::TESTER_EN_ADDR);
   assign hit_le = addr_hit(reg_addr, gcis_pkg::LINE_EN_ADDR);

   gcis_enable_reg u_en_framer (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .wr_sel(reg_wr & hit_fe), // R06
      .wr_data(reg_wdata),
      .value(framer_enable_per_channel)
   );
   gcis_enable_reg u_en_tester (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .wr_sel(reg_wr & hit_te), // R07
      .wr_data(reg_wdata),
      .value(tester_enable_per_channel)
   );
   gcis_enable_reg u_en_line (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .wr_sel(reg_wr & hit_le), // R08
      .wr_data(reg_wdata),
      .value(line_enable_per_channel)
   );

   // summaries are not write targets; they only follow the sources
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         framer_sum_r <= gcis_pkg::SUMMARY_RESET;
         tester_sum_r <= gcis_pkg::SUMMARY_RESET;
         line_sum_r <= gcis_pkg::SUMMARY_RESET;
      end else begin
         framer_sum_r <= framer_sync; // R01 R05 R11
         tester_sum_r <= tester_sync; // R03 R05 R11
         line_sum_r <= line_sync; // R04 R05 R11
      end
   end

   assign irq_nxt = |((framer_sum_r & framer_enable_per_channel)
                    | (tester_sum_r & tester_enable_per_channel)
                    | (line_sum_r & line_enable_per_channel)); // R10

   assign rdata_nxt = !reg_rd ? gcis_pkg::UNMAPPED_READ :
                      hit_fs ? framer_sum_r :
                      hit_ts ? tester_sum_r :
                      hit_ls ? line_sum_r :
                      hit_fe ? framer_enable_per_channel :
                      hit_te ? tester_enable_per_channel :
                      hit_le ? line_enable_per_channel :
                      gcis_pkg::UNMAPPED_READ;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_r <= gcis_pkg::UNMAPPED_READ;
         irq_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         irq_r <= irq_nxt; // R10
      end
   end

   assign reg_rdata = rdata_r;
   assign irq_out = irq_r;
   assign framer_pending_per_channel = framer_sum_r;
   assign tester_pending_per_channel = tester_sum_r;
   assign line_pending_per_channel = line_sum_r;
endmodule : gcis_irq_summary

/* File: tb/gcis_irq_summary_props.sv */
`timescale 1ns/100ps
module gcis_irq_summary_props (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] framer_irq_in,
   input wire logic [7:0] tester_irq_in,
   input wire logic [7:0] line_irq_in,
   input wire logic irq_out,
   input wire logic [7:0] framer_pending_per_channel,
   input wire logic [7:0] tester_pending_per_channel,
   input wire logic [7:0] line_pending_per_channel
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   property p_fr;
      $stable(framer_irq_in)[*6] |-> framer_pending_per_channel == framer_irq_in;
   endproperty
   a_fr: assert property (p_fr) else $error("framer summary off");
   property p_te;
      $stable(tester_irq_in)[*6] |-> tester_pending_per_channel == tester_irq_in;
   endproperty
   a_te: assert property (p_te) else $error("tester summary off");
   property p_li;
      $stable(line_irq_in)[*6] |-> line_pending_per_channel == line_irq_in;
   endproperty
   a_li: assert property (p_li) else $error("line summary off");
   property p_irq;
      irq_out |-> $past(|{framer_pending_per_channel,
         tester_pending_per_channel, line_pending_per_channel});
   endproperty
   a_irq: assert property (p_irq) else $error("irq without pending");
   property p_idle;
      !$past(reg_rd) |-> reg_rdata == 8'h00;
   endproperty
   a_idle: assert property (p_idle) else $error("rdata not idle");
   property p_rdf;
      reg_rd && reg_addr == 16'h00f9 ##1 $stable(framer_pending_per_channel)
         |-> reg_rdata == framer_pending_per_channel;
   endproperty
   a_rdf: assert property (p_rdf) else $error("framer read off");
   property p_rdt;
      reg_rd && reg_addr == 16'h00fa ##1 $stable(tester_pending_per_channel)
         |-> reg_rdata == tester_pending_per_channel;
   endproperty
   a_rdt: assert property (p_rdt) else $error("tester read off");
   property p_unm;
      reg_rd && reg_addr == 16'h0000 |=> reg_rdata == 8'h00;
   endproperty
   a_unm: assert property (p_unm) else $error("unmapped read off");
   c_irq: cover property ($rose(irq_out));
   c_wr: cover property (reg_wr && reg_addr == 16'h00fe);
   c_rd: cover property (reg_rd && reg_addr == 16'h00f9);
endmodule : gcis_irq_summary_props

/* File: tb/gcis_src_model.sv */
`timescale 1ns/100ps
// sub-unit sources raise and drop their levels on the sys_clk rising edge
module gcis_src_model (
   input wire logic sys_clk,
   input wire logic [7:0] fr_set,
   input wire logic [7:0] te_set,
   input wire logic [7:0] li_set,
   output logic [7:0] framer_irq_in,
   output logic [7:0] tester_irq_in,
   output logic [7:0] line_irq_in
);
   always_ff @(posedge sys_clk) begin
      framer_irq_in <= fr_set;
      tester_irq_in <= te_set;
      line_irq_in <= li_set;
   end
endmodule : gcis_src_model

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] fr_set = 8'h00, te_set = 8'h00, li_set = 8'h00;
   logic [7:0] reg_rdata, framer_irq_in, tester_irq_in, line_irq_in;
   logic [7:0] framer_pending_per_channel, tester_pending_per_channel;
   logic [7:0] line_pending_per_channel;
   logic irq_out;
   int n_fail = 0;
   int checks = 0;
   initial forever #5 sys_clk = ~sys_clk;
   gcis_src_model u_gcis_src_model (.sys_clk, .fr_set, .te_set, .li_set,
      .framer_irq_in, .tester_irq_in, .line_irq_in);
   gcis_irq_summary u_gcis_irq_summary (.sys_clk, .resetn, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .framer_irq_in,
      .tester_irq_in, .line_irq_in, .irq_out, .framer_pending_per_channel,
      .tester_pending_per_channel, .line_pending_per_channel);
   task automatic chk(input string nm, input logic [7:0] seen, e);
      checks++;
      if (seen !== e) begin
         n_fail++;
         $display("mismatch %s exp %h seen %h", nm, e, seen);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rc(input logic [15:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk("rdata", reg_rdata, e);
   endtask : rc
   task automatic give_verdict;
      if (n_fail == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      for (int a = 'hf9; a <= 'hfe; a++) rc(a[15:0], 8'h00);
      rc(16'h0000, 8'h00);
      wr(16'h00fc, 8'h25);
      wr(16'h00fd, 8'h5a);
      wr(16'h00fe, 8'h3c);
      wr(16'h00f9, 8'hff);
      rc(16'h00fc, 8'h25);
      rc(16'h00fd, 8'h5a);
      rc(16'h00fe, 8'h3c);
      rc(16'h00f9, 8'h00);
      fr_set <= 8'h82;
      te_set <= 8'h01;
      li_set <= 8'h80;
      repeat (8) @(posedge sys_clk);
      rc(16'h00f9, 8'h82);
      rc(16'h00fa, 8'h01);
      rc(16'h00fb, 8'h80);
      chk("irq", {7'h00, irq_out}, 8'h00);
      wr(16'h00fe, 8'h80);
      repeat (2) @(posedge sys_clk);
      #1 chk("irq", {7'h00, irq_out}, 8'h01);
      li_set <= 8'h00;
      repeat (8) @(posedge sys_clk);
      rc(16'h00fb, 8'h00);
      chk("irq", {7'h00, irq_out}, 8'h00);
      chk("fpend", framer_pending_per_channel, 8'h82);
      chk("tpend", tester_pending_per_channel, 8'h01);
      chk("lpend", line_pending_per_channel, 8'h00);
      wr(16'h00fc, 8'h02);
      repeat (2) @(posedge sys_clk);
      #1 chk("irq", {7'h00, irq_out}, 8'h01);
      wr(16'h00fc, 8'h00);
      repeat (2) @(posedge sys_clk);
      #1 chk("irq", {7'h00, irq_out}, 8'h00);
      wr(16'h00fd, 8'h01);
      repeat (2) @(posedge sys_clk);
      #1 chk("irq", {7'h00, irq_out}, 8'h01);
      te_set <= 8'h00;
      repeat (8) @(posedge sys_clk);
      #1 chk("irq", {7'h00, irq_out}, 8'h00);
      give_verdict;
   end
endmodule : testbench
bind gcis_irq_summary gcis_irq_summary_props u_gcis_irq_summary_props (.*);
